// >>> src/bsi_params.svh
// Constants for the boundary-scan instruction logic: opcodes, lengths, fields.
// Assumes nothing; included by the package and by the design modules.
`ifndef BSI_PARAMS_SVH
`define BSI_PARAMS_SVH

// Instruction register width and opcodes
`define BSI_IR_W 3
`define BSI_OP_EXTEST 3'h0
`define BSI_OP_IDCODE 3'h1
`define BSI_OP_SAMPLE 3'h2
`define BSI_OP_HIGHZ 3'h3
`define BSI_OP_CLAMP 3'h4
`define BSI_OP_BYPASS 3'h7
// Pattern loaded into the instruction shifter on capture
`define BSI_IR_CAPTURE 3'h1
// Reset value of the instruction register
`define BSI_IR_RESET 3'h1

// Identification register layout
`define BSI_ID_W 32
`define BSI_ID_VER_W 4
`define BSI_ID_PART_W 16
`define BSI_ID_MFR_W 11
`define BSI_ID_LSB 1'b1

// Boundary register: input cells low, output cells high
`define BSI_PINS 4
`define BSI_BSR_W 8
`define BSI_BSR_OUT_LSB 4

`endif

// >>> src/bsi_pkg.sv
// Types shared by the boundary-scan instruction logic.
// Assumes bsi_params.svh is on the include path.
`include "bsi_params.svh"

package bsi_pkg;

  // Test access port controller states, one-hot
  typedef enum logic [15:0] {
    ST_TLR    = 16'h0001,
    ST_RTI    = 16'h0002,
    ST_SEL_DR = 16'h0004,
    ST_CAP_DR = 16'h0008,
    ST_SH_DR  = 16'h0010,
    ST_EX1_DR = 16'h0020,
    ST_PA_DR  = 16'h0040,
    ST_EX2_DR = 16'h0080,
    ST_UPD_DR = 16'h0100,
    ST_SEL_IR = 16'h0200,
    ST_CAP_IR = 16'h0400,
    ST_SH_IR  = 16'h0800,
    ST_EX1_IR = 16'h1000,
    ST_PA_IR  = 16'h2000,
    ST_EX2_IR = 16'h4000,
    ST_UPD_IR = 16'h8000
  } bsi_tap_e;

  // Data register selected between serial in and out
  typedef enum logic [2:0] {
    SEL_BSR = 3'h1,
    SEL_ID  = 3'h2,
    SEL_BYP = 3'h4
  } bsi_sel_e;

  typedef struct packed {
    bsi_tap_e st;
  } bsi_tapst_s;

  // Decoded controller strobes
  typedef struct packed {
    logic tlr;
    logic cap_dr;
    logic sh_dr;
    logic upd_dr;
    logic cap_ir;
    logic sh_ir;
    logic upd_ir;
  } bsi_tapsig_s;

  // Pin control mode
  typedef struct packed {
    logic drive;
    logic highz;
  } bsi_mode_s;

  // Test clock domain state
  typedef struct packed {
    logic [`BSI_IR_W-1:0] ir;
    logic [`BSI_IR_W-1:0] ir_sh;
    logic [`BSI_BSR_W-1:0] bsr;
    logic [`BSI_PINS-1:0] upd;
    logic [`BSI_ID_W-1:0] idr;
    logic byp;
    bsi_mode_s mode;
    logic upd_tog;
  } bsi_tck_s;

  // System clock domain state
  typedef struct packed {
    logic [`BSI_PINS-1:0] pin_out;
    logic [`BSI_PINS-1:0] pin_oe;
    logic [`BSI_PINS-1:0] core_in;
    logic [`BSI_PINS-1:0] drive_val;
    logic tog_seen;
    bsi_mode_s mode_smp;
    bsi_mode_s mode;
  } bsi_clk_s;

endpackage

// >>> src/bsi_sync2.sv
// Two flip-flop synchroniser for levels, any width.
// Assumes each bit is a slow level; multi-bit words are only snapshots.
`timescale 1ns/1ps

module bsi_sync2 #(
  parameter int W = 1
) (
  input wire logic clk,
  input wire logic rst_n,
  input wire logic [W-1:0] d,
  output logic [W-1:0] q
);
  typedef struct packed {
    logic [W-1:0] s1;
    logic [W-1:0] s2;
  } bsi_sync_s;

  bsi_sync_s r;
  bsi_sync_s next_r;

  // First stage feeds only the second stage
  always_comb begin
    next_r.s1 = d;
    next_r.s2 = r.s1;
  end

  always_ff @(posedge clk) begin
    if (!rst_n) begin
      r <= '0;
    end else begin
      r <= next_r;
    end
  end

  assign q = r.s2;
endmodule

// >>> src/bsi_tap_ctrl.sv
// Test access port controller: sixteen-state machine on the test clock.
// Assumes tms is launched by the tester relative to tck; trst_n synchronous to tck.
`timescale 1ns/1ps
`include "bsi_params.svh"

module bsi_tap_ctrl
  import bsi_pkg::*;
(
  input wire logic tck,
  input wire logic trst_n,
  input wire logic tms,
  output bsi_tapsig_s sig
);
  bsi_tapst_s r;
  bsi_tapst_s next_r;

  // Standard state walk; five high tms reach reset from anywhere
  always_comb begin
    next_r = r;
    case (r.st)
      ST_TLR: next_r.st = tms ? ST_TLR : ST_RTI;
      ST_RTI: next_r.st = tms ? ST_SEL_DR : ST_RTI;
      ST_SEL_DR: next_r.st = tms ? ST_SEL_IR : ST_CAP_DR;
      ST_CAP_DR: next_r.st = tms ? ST_EX1_DR : ST_SH_DR;
      ST_SH_DR: next_r.st = tms ? ST_EX1_DR : ST_SH_DR;
      ST_EX1_DR: next_r.st = tms ? ST_UPD_DR : ST_PA_DR;
      ST_PA_DR: next_r.st = tms ? ST_EX2_DR : ST_PA_DR;
      ST_EX2_DR: next_r.st = tms ? ST_UPD_DR : ST_SH_DR;
      ST_UPD_DR: next_r.st = tms ? ST_SEL_DR : ST_RTI;
      ST_SEL_IR: next_r.st = tms ? ST_TLR : ST_CAP_IR;
      ST_CAP_IR: next_r.st = tms ? ST_EX1_IR : ST_SH_IR;
      ST_SH_IR: next_r.st = tms ? ST_EX1_IR : ST_SH_IR;
      ST_EX1_IR: next_r.st = tms ? ST_UPD_IR : ST_PA_IR;
      ST_PA_IR: next_r.st = tms ? ST_EX2_IR : ST_PA_IR;
      ST_EX2_IR: next_r.st = tms ? ST_UPD_IR : ST_SH_IR;
      ST_UPD_IR: next_r.st = tms ? ST_SEL_DR : ST_RTI;
      default: next_r.st = ST_TLR;
    endcase
  end

  always_ff @(posedge tck) begin
    if (!trst_n) begin
      r.st <= ST_TLR;
    end else begin
      r <= next_r;
    end
  end

  // Strobes decoded from the current state
  always_comb begin
    sig.tlr = (r.st == ST_TLR);
    sig.cap_dr = (r.st == ST_CAP_DR);
    sig.sh_dr = (r.st == ST_SH_DR);
    sig.upd_dr = (r.st == ST_UPD_DR);
    sig.cap_ir = (r.st == ST_CAP_IR);
    sig.sh_ir = (r.st == ST_SH_IR);
    sig.upd_ir = (r.st == ST_UPD_IR);
  end
endmodule

// >>> src/bsi_top.sv
// Boundary-scan instruction logic: instruction decode, data registers, pin control.
// Assumes the tester owns tck, tms, tdi and trst_n; core pins arrive on clk.
//
// Operation
// - Opcode 000 scans boundary register, drives pins from it, captures pin inputs.
// - Opcode 001 scans identification register; chip keeps running normally.
// - Opcode 010 scans boundary register and snapshots signals entering and leaving.
// - During opcode 010 shifted values are kept for a later external test.
// - Opcode 011 turns every output to high impedance while active.
// - Opcode 011 puts the one-bit bypass stage between serial in and out.
// - Opcode 100 drives outputs from held boundary values, scans bypass stage.
// - Opcode 111 passes serial data through one bypass stage, chip unaffected.
// - Identification word holds version, part, maker fields and a constant one.
// - Test port uses reset, clock, mode select, serial in and serial out.
`timescale 1ns/1ps
`include "bsi_params.svh"

module bsi_top
  import bsi_pkg::*;
#(
  // Identification values; all arbitrary
  parameter logic [`BSI_ID_VER_W-1:0] ID_VERSION = 4'h1,
  parameter logic [`BSI_ID_PART_W-1:0] ID_PART = 16'h5a3c,
  parameter logic [`BSI_ID_MFR_W-1:0] ID_MAKER = 11'h2b6
) (
  input wire logic clk,
  input wire logic nrst,
  input wire logic tck,
  input wire logic trst_n,
  input wire logic tms,
  input wire logic tdi,
  output logic tdo,
  output logic tdo_oe,
  input wire logic [`BSI_PINS-1:0] core_out,
  input wire logic core_oe,
  output logic [`BSI_PINS-1:0] core_in,
  input wire logic [`BSI_PINS-1:0] pin_in,
  output logic [`BSI_PINS-1:0] pin_out,
  output logic [`BSI_PINS-1:0] pin_oe
);
  localparam logic [`BSI_ID_W-1:0] ID_WORD = {ID_VERSION, ID_PART, ID_MAKER, `BSI_ID_LSB};

  bsi_tapsig_s tap;
  bsi_tck_s t;
  bsi_tck_s next_t;
  bsi_clk_s c;
  bsi_clk_s next_c;
  bsi_sel_e sel;
  logic [`BSI_PINS-1:0] pin_in_t;
  logic [`BSI_PINS-1:0] core_out_t;
  logic [`BSI_PINS-1:0] pin_in_c;
  bsi_mode_s mode_c;
  logic tog_c;

  // Opcode to selected data register; unlisted codes fall to bypass
  function automatic bsi_sel_e sel_of(input logic [`BSI_IR_W-1:0] op);
    case (op)
      `BSI_OP_EXTEST: sel_of = SEL_BSR;
      `BSI_OP_IDCODE: sel_of = SEL_ID;
      `BSI_OP_SAMPLE: sel_of = SEL_BSR;
      `BSI_OP_HIGHZ: sel_of = SEL_BYP;
      `BSI_OP_CLAMP: sel_of = SEL_BYP;
      `BSI_OP_BYPASS: sel_of = SEL_BYP;
      default: sel_of = SEL_BYP;
    endcase
  endfunction

  // Opcode to pin control mode; only three codes take the pins from the core
  function automatic bsi_mode_s mode_of(input logic [`BSI_IR_W-1:0] op);
    mode_of = '0;
    case (op)
      `BSI_OP_EXTEST: mode_of.drive = 1'b1;
      `BSI_OP_CLAMP: mode_of.drive = 1'b1;
      `BSI_OP_HIGHZ: mode_of.highz = 1'b1;
      default: mode_of = '0;
    endcase
  endfunction

  bsi_tap_ctrl u_tap (
    .tck(tck),
    .trst_n(trst_n),
    .tms(tms),
    .sig(tap)
  );

  // Pads and core outputs sampled into the test clock domain for capture
  bsi_sync2 #(.W(`BSI_PINS)) u_pin_t (
    .clk(tck),
    .rst_n(trst_n),
    .d(pin_in),
    .q(pin_in_t)
  );

  bsi_sync2 #(.W(`BSI_PINS)) u_core_t (
    .clk(tck),
    .rst_n(trst_n),
    .d(core_out),
    .q(core_out_t)
  );

  // Mode and update toggle carried into the system clock domain
  bsi_sync2 #(.W(3)) u_ctl_c (
    .clk(clk),
    .rst_n(nrst),
    .d({t.mode, t.upd_tog}),
    .q({mode_c, tog_c})
  );

  // Pads into the core on the system clock
  bsi_sync2 #(.W(`BSI_PINS)) u_pin_c (
    .clk(clk),
    .rst_n(nrst),
    .d(pin_in),
    .q(pin_in_c)
  );

  assign sel = sel_of(t.ir);

  // Test clock domain: instruction and data registers
  always_comb begin
    next_t = t;
    if (tap.cap_ir) begin
      next_t.ir_sh = `BSI_IR_CAPTURE;
    end
    if (tap.sh_ir) begin
      next_t.ir_sh = {tdi, t.ir_sh[`BSI_IR_W-1:1]};
    end
    // New instruction and its pin mode take effect together
    if (tap.upd_ir) begin
      next_t.ir = t.ir_sh;
      next_t.mode = mode_of(t.ir_sh);
    end
    if (tap.cap_dr) begin
      case (sel)
        SEL_BSR: next_t.bsr = {core_out_t, pin_in_t};
        SEL_ID: next_t.idr = ID_WORD;
        default: next_t.byp = 1'b0;
      endcase
    end
    if (tap.sh_dr) begin
      case (sel)
        SEL_BSR: next_t.bsr = {tdi, t.bsr[`BSI_BSR_W-1:1]};
        SEL_ID: next_t.idr = {tdi, t.idr[`BSI_ID_W-1:1]};
        default: next_t.byp = tdi;
      endcase
    end
    // Preloaded output values held until the next boundary update
    if (tap.upd_dr && sel == SEL_BSR) begin
      next_t.upd = t.bsr[`BSI_BSR_W-1:`BSI_BSR_OUT_LSB];
      next_t.upd_tog = ~t.upd_tog;
    end
    // Reset state restores identify and releases the pins
    if (tap.tlr) begin
      next_t.ir = `BSI_IR_RESET;
      next_t.mode = '0;
    end
  end

  always_ff @(posedge tck) begin
    if (!trst_n) begin
      t <= '{ir: `BSI_IR_RESET, default: '0};
    end else begin
      t <= next_t;
    end
  end

  // Serial out is the low bit of whichever register is in the path
  always_comb begin
    tdo_oe = tap.sh_dr | tap.sh_ir;
    if (tap.sh_ir) begin
      tdo = t.ir_sh[0];
    end else begin
      case (sel)
        SEL_BSR: tdo = t.bsr[0];
        SEL_ID: tdo = t.idr[0];
        default: tdo = t.byp;
      endcase
    end
  end

  // System clock domain: pin muxing; update word taken only after its toggle lands
  // Both mode bits may flip at once and land a clock apart; a mode is taken only
  // once two samples agree, so pins never see a mix of old and new mode
  always_comb begin
    next_c = c;
    next_c.tog_seen = tog_c;
    if (tog_c != c.tog_seen) begin
      next_c.drive_val = t.upd; // Stable since the toggle flipped
    end
    next_c.mode_smp = mode_c;
    if (mode_c == c.mode_smp) begin
      next_c.mode = mode_c; // Costs two clocks of latency
    end
    next_c.pin_out = c.mode.drive ? c.drive_val : core_out;
    if (c.mode.highz) begin
      next_c.pin_oe = '0;
    end else if (c.mode.drive) begin
      next_c.pin_oe = '1;
    end else begin
      next_c.pin_oe = {`BSI_PINS{core_oe}};
    end
    next_c.core_in = pin_in_c;
  end

  always_ff @(posedge clk) begin
    if (!nrst) begin
      c <= '0;
    end else begin
      c <= next_c;
    end
  end

  assign pin_out = c.pin_out;
  assign pin_oe = c.pin_oe;
  assign core_in = c.core_in;

  // Checks in the test clock domain
  sequence five_high_s;
    tms [*5];
  endsequence

  sequence extest_load_s;
    tap.upd_ir && t.ir_sh == `BSI_OP_EXTEST;
  endsequence

  sequence id_capture_s;
    tap.cap_dr && t.ir == `BSI_OP_IDCODE;
  endsequence

  extest_mode_a: assert property (@(posedge tck) disable iff (!trst_n)
    extest_load_s |=> t.mode.drive && !t.mode.highz && sel == SEL_BSR)
    else $error("extest did not select boundary drive");

  idcode_capture_a: assert property (@(posedge tck) disable iff (!trst_n)
    id_capture_s |=> t.idr == ID_WORD && t.mode == '0)
    else $error("identify capture wrong or pins disturbed");

  sample_capture_a: assert property (@(posedge tck) disable iff (!trst_n)
    tap.cap_dr && t.ir == `BSI_OP_SAMPLE
      |=> t.bsr == {$past(core_out_t), $past(pin_in_t)} && t.mode == '0)
    else $error("sample snapshot wrong");

  preload_keep_a: assert property (@(posedge tck) disable iff (!trst_n)
    tap.upd_dr && t.ir == `BSI_OP_SAMPLE
      |=> t.upd == $past(t.bsr[`BSI_BSR_W-1:`BSI_BSR_OUT_LSB]) && t.upd_tog != $past(t.upd_tog))
    else $error("preload values not kept");

  highz_bypass_a: assert property (@(posedge tck) disable iff (!trst_n)
    t.ir == `BSI_OP_HIGHZ && tap.sh_dr |=> tdo == $past(tdi) || !tap.sh_dr)
    else $error("highz path is not one stage");

  clamp_path_a: assert property (@(posedge tck) disable iff (!trst_n)
    t.ir == `BSI_OP_CLAMP && tap.sh_dr |-> tdo == t.byp && t.mode.drive && !t.mode.highz)
    else $error("clamp path or mode wrong");

  bypass_stage_a: assert property (@(posedge tck) disable iff (!trst_n)
    t.ir == `BSI_OP_BYPASS && tap.cap_dr |=> t.byp == 1'b0 && t.mode == '0)
    else $error("bypass capture not zero");

  id_layout_a: assert property (@(posedge tck) disable iff (!trst_n)
    id_capture_s |=> t.idr[0] == `BSI_ID_LSB
      && t.idr[`BSI_ID_W-1:`BSI_ID_W-`BSI_ID_VER_W] == ID_VERSION)
    else $error("identify fields misplaced");

  tap_reset_a: assert property (@(posedge tck) disable iff (!trst_n)
    five_high_s |=> tap.tlr)
    else $error("five high tms did not reset");

  unlisted_op_a: assert property (@(posedge tck) disable iff (!trst_n)
    (t.ir == 3'h5 || t.ir == 3'h6) |-> sel == SEL_BYP && t.mode == '0)
    else $error("unlisted opcode not bypass");

  reset_ir_a: assert property (@(posedge tck) disable iff (!trst_n)
    tap.tlr |=> t.ir == `BSI_OP_IDCODE)
    else $error("reset did not load identify");

  // Checks in the system clock domain
  sequence highz_held_s;
    c.mode.highz [*2];
  endsequence

  highz_pins_a: assert property (@(posedge clk) disable iff (!nrst)
    highz_held_s |=> pin_oe == '0)
    else $error("outputs enabled during highz");

  clamp_pins_a: assert property (@(posedge clk) disable iff (!nrst)
    c.mode.drive && !c.mode.highz |=> pin_out == $past(c.drive_val) && pin_oe == '1)
    else $error("clamped outputs not from held values");

  normal_pins_a: assert property (@(posedge clk) disable iff (!nrst)
    c.mode == '0 |=> pin_out == $past(core_out))
    else $error("normal mode disturbed outputs");

  mode_whole_a: assert property (@(posedge clk) disable iff (!nrst)
    !(c.mode.drive && c.mode.highz))
    else $error("pin mode taken half changed");
endmodule

// >>> sim/bsi_tester.sv
// Tester model: walks the test port from its own 30 ns clock.
// Assumes the scan logic changes tdo after rising tck; tck parks low between frames.
`timescale 1ns/1ps

module bsi_tester (
  output logic tck,
  output logic trst_n,
  output logic tms,
  output logic tdi,
  input wire logic tdo
);
  // Lines idle at their pull-up levels, clock parked low
  initial begin
    tck = 1'b0;
    trst_n = 1'b1;
    tms = 1'b1;
    tdi = 1'b1;
  end

  // One test clock: launch after the fall, sample tdo just before the rise
  task automatic step(input logic m, input logic d, output logic q);
    #1 tms = m;
    tdi = d;
    #12 q = tdo;
    #2 tck = 1'b1;
    #15 tck = 1'b0;
  endtask

  // Idle to shift, n bits LSB first, update, back to idle
  task automatic frame(input logic ir, input int n, input logic [31:0] din,
                       output logic [31:0] dout);
    logic q;
    dout = '0;
    step(1'b1, 1'b1, q);
    if (ir) step(1'b1, 1'b1, q);
    step(1'b0, 1'b1, q);
    step(1'b0, 1'b1, q);
    for (int i = 0; i < n; i++) begin
      step(i == n - 1, din[i], q);
      dout[i] = q;
    end
    step(1'b1, 1'b1, q);
    step(1'b0, 1'b1, q);
    tdi = 1'b1; // Released line returns to its pull-up
  endtask

  // Reset by pin, or by five high mode-select clocks, then park in idle
  task automatic reset_tap(input logic by_pin);
    logic q;
    trst_n = ~by_pin;
    repeat (by_pin ? 2 : 5) step(1'b1, 1'b1, q);
    trst_n = 1'b1;
    step(1'b0, 1'b1, q);
  endtask
endmodule

// >>> sim/boundary_scan_instruction_logic_test.sv
// Self-checking bench: every opcode in a shuffled order, random pads each time.
// Assumes the tester model drives the test port; pads and core change on falling clk.
`timescale 1ns/1ps
`include "bsi_params.svh"

module boundary_scan_instruction_logic_test;
  // Identification values; all arbitrary
  localparam logic [3:0] VER = 4'h9;
  localparam logic [15:0] PART = 16'h1234;
  localparam logic [10:0] MAKER = 11'h155;
  // SAMPLE before EXTEST, CLAMP after an update, then the bypass family
  localparam logic [2:0] OPS [8] = '{3'h1, 3'h2, 3'h0, 3'h4, 3'h3, 3'h7, 3'h5, 3'h6};

  logic clk, nrst, tck, trst_n, tms, tdi, tdo, tdo_oe, core_oe;
  logic [`BSI_PINS-1:0] core_out, core_in, pin_in, pin_out, pin_oe, upd;
  logic [31:0] rng, got;
  logic [7:0] m;
  int n_mismatch, n_checks;

  bsi_top #(.ID_VERSION(VER), .ID_PART(PART), .ID_MAKER(MAKER)) i_dut (
    .clk(clk), .nrst(nrst), .tck(tck), .trst_n(trst_n), .tms(tms), .tdi(tdi),
    .tdo(tdo), .tdo_oe(tdo_oe), .core_out(core_out), .core_oe(core_oe),
    .core_in(core_in), .pin_in(pin_in), .pin_out(pin_out), .pin_oe(pin_oe)
  );

  bsi_tester i_tap (.tck(tck), .trst_n(trst_n), .tms(tms), .tdi(tdi), .tdo(tdo));

  // 125 MHz system clock
  initial begin
    clk = 1'b0;
    forever #4 clk = ~clk;
  end

  // Run needs about 30 us; a hang is cut well after that
  initial begin
    #100000;
    n_mismatch++;
    print_verdict();
  end

  task automatic chk(input logic [31:0] seen, input logic [31:0] exp);
    n_checks++;
    if (seen !== exp) begin
      n_mismatch++;
      $display("[FAIL] %0t seen %h expected %h", $time, seen, exp);
    end
  endtask

  task automatic print_verdict();
    $display("checks %0d mismatches %0d", n_checks, n_mismatch);
    if (n_mismatch == 0 && n_checks > 0) begin
      $display("TB: PASS");
    end else begin
      $display("TB: FAIL");
    end
    $finish;
  endtask

  function automatic logic [31:0] xs(input logic [31:0] s);
    logic [31:0] v;
    v = s ^ (s << 13);
    v = v ^ (v >> 17);
    return v ^ (v << 5);
  endfunction

  function automatic logic [31:0] id_word();
    return {VER, PART, MAKER, 1'b1};
  endfunction

  // Enables: driven in external test and clamp, off in high impedance
  function automatic logic [3:0] exp_oe(input logic [2:0] op);
    case (op)
      3'h0, 3'h4: return 4'hf;
      3'h3: return 4'h0;
      default: return {4{core_oe}};
    endcase
  endfunction

  function automatic logic [3:0] exp_out(input logic [2:0] op);
    return (op == 3'h0 || op == 3'h4) ? upd : core_out;
  endfunction

  // Boundary cells capture pads and core outputs; bypass delays by one stage
  function automatic logic [7:0] exp_scan(input logic [2:0] op, input logic [7:0] d);
    logic [31:0] id;
    id = id_word();
    case (op)
      3'h0, 3'h2: return {core_out, pin_in};
      3'h1: return id[7:0];
      default: return {d[6:0], 1'b0};
    endcase
  endfunction

  // Test reset, by pin or by mode select alone, must leave identify in place
  task automatic id_check(input logic by_pin);
    i_tap.reset_tap(by_pin);
    chk(32'(tdo_oe), 32'h0);
    i_tap.frame(1'b0, 32, 32'h0, got);
    chk(got, id_word());
    i_tap.frame(1'b1, 3, 32'h1, got);
    chk(got, 32'(`BSI_IR_CAPTURE));
  endtask

  // Main sequence
  initial begin
    nrst = 1'b0;
    core_out = '0;
    core_oe = 1'b0;
    pin_in = '0;
    upd = '0;
    rng = 32'h90180df9;
    n_mismatch = 0;
    n_checks = 0;
    repeat (16) @(negedge clk);
    nrst = 1'b1;
    id_check(1'b1);
    for (int r = 0; r < 4; r++) begin
      foreach (OPS[k]) begin
        @(negedge clk);
        rng = xs(rng);
        core_out = rng[3:0];
        core_oe = rng[4];
        pin_in = rng[11:8];
        i_tap.frame(1'b1, 3, 32'(OPS[k]), got);
        repeat (8) @(negedge clk);
        chk(32'(pin_oe), 32'(exp_oe(OPS[k])));
        if (OPS[k] != 3'h3) chk(32'(pin_out), 32'(exp_out(OPS[k])));
        chk(32'(core_in), 32'(pin_in));
        m = (OPS[k] < 3'h3) ? 8'hff : 8'hfe;
        i_tap.frame(1'b0, 8, 32'(rng[23:16]), got);
        chk(32'(got[7:0] & m), 32'(exp_scan(OPS[k], rng[23:16]) & m));
        // Preloaded word is what external test and clamp drive next
        if (OPS[k] == 3'h0 || OPS[k] == 3'h2) upd = rng[23:20];
      end
    end
    id_check(1'b0);
    print_verdict();
  end
endmodule
